// >>> rtl/gpm_geometry_primitive_mode_regs.v
// Purpose: Geometry line and triangle mode settings plus display-list entry port
// Assumes: Mode writes arrive from the display-list command processor
// Notes: Settings are latched per primitive at primitive start
// Overview of operation
// - Thick-line orientation: principal axis or theoretical line
// - Line bit 9 enables border primitive
// - Bit 8 enables shadow, line and triangle
// - Line bit 4: 0 clears dash reference
// - Line bit 2 draws end point, never strips
// - Line bit 0 enables line anti-aliasing
// - Triangle mode at 48 hex, begin to end
// - Triangle bit 2 selects front face winding
// - Triangle bit 0 culls back; polygons unaffected
// - Extension bit 10 set skips top-left rule
// - Write-only FIFO entry word at 400 hex
// - Line thick, dash-orientation, border and shadow bits only with vertex enables cleared
`include "gpm_map.vh"
module gpm_geometry_primitive_mode_regs (
    input wire clk_sys,
    input wire rst_n,
    input wire cmdWrEn,
    input wire [11:0] cmdWrAddr,
    input wire [31:0] cmdWrData,
    output wire cmdWrReady,
    input wire primStart,
    input wire [1:0] primKind,
    input wire primActive,
    output reg wordValid_q,
    output reg [31:0] wordData_q,
    input wire wordReady,
    output reg thickLineOrientation_q,
    output reg thickJointCorrection_q,
    output reg dashPatternOrientation_q,
    output reg borderPrimitiveEnable_q,
    output reg shadowPrimitiveEnable_q,
    output reg dashReferenceClear_q,
    output reg endPointDraw_q,
    output reg lineAntialias_q,
    output reg frontFaceWinding_q,
    output reg backFaceCull_q,
    output reg topLeftRuleDisable_q,
    output reg primInTriangleRange_q
);
    // Stored settings; CPU cannot reach these, only the command path
    reg [31:0] vertexMode_q;
    reg [31:0] lineMode_q;
    reg [31:0] lineModeExt_q;
    reg [31:0] triangleMode_q;
    reg [31:0] triangleModeExt_q;
    wire fifoWr;
    wire fifoWordValid;
    wire [31:0] fifoWordData;
    wire extOk;
    wire isLine;
    wire isTri;

    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = cmdWrEn && (a == ofs);
        end
    endfunction

    assign fifoWr = hit(cmdWrAddr, `GPM_OFS_FIFO_PORT);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vertexMode_q <= `GPM_RST_MODE;
            lineMode_q <= `GPM_RST_MODE;
            lineModeExt_q <= `GPM_RST_MODE;
            triangleMode_q <= `GPM_RST_MODE;
            triangleModeExt_q <= `GPM_RST_MODE;
        end else begin
            if (hit(cmdWrAddr, `GPM_OFS_VERTEX_MODE)) begin
                vertexMode_q <= cmdWrData;
            end else if (hit(cmdWrAddr, `GPM_OFS_LINE_MODE)) begin
                lineMode_q <= cmdWrData;
            end else if (hit(cmdWrAddr, `GPM_OFS_TRIANGLE_MODE)) begin
                triangleMode_q <= cmdWrData;
            end else if (hit(cmdWrAddr, `GPM_OFS_LINE_MODE_EXT)) begin
                lineModeExt_q <= cmdWrData;
            end else if (hit(cmdWrAddr, `GPM_OFS_TRIANGLE_MODE_EXT)) begin
                triangleModeExt_q <= cmdWrData;
            end
        end
    end

    gpm_fifo_port uFifoPort (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wrEn(fifoWr),
        .wrData(cmdWrData),
        .portReady(cmdWrReady),
        .wordValid_q(fifoWordValid),
        .wordData_q(fifoWordData),
        .wordReady(wordReady)
    );

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wordValid_q <= 1'b0;
            wordData_q <= 32'h00000000;
        end else begin
            wordValid_q <= fifoWordValid;
            wordData_q <= fifoWordData;
        end
    end

    // Thick, dash-orientation, border and shadow line functions are gated when any vertex attribute is enabled
    assign extOk = ~vertexMode_q[`GPM_BIT_VTX_COLOR] & ~vertexMode_q[`GPM_BIT_VTX_DEPTH]
        & ~vertexMode_q[`GPM_BIT_VTX_TEX];
    assign isLine = (primKind == `GPM_MODE_LINE) || (primKind == `GPM_MODE_STRIP);
    assign isTri = (primKind == `GPM_MODE_TRI) || (primKind == `GPM_MODE_POLY);

    // Latch at primitive start so mid-primitive writes do not disturb it
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            thickLineOrientation_q <= 1'b0;
            thickJointCorrection_q <= 1'b0;
            dashPatternOrientation_q <= 1'b0;
            borderPrimitiveEnable_q <= 1'b0;
            shadowPrimitiveEnable_q <= 1'b0;
            dashReferenceClear_q <= 1'b0;
            endPointDraw_q <= 1'b0;
            lineAntialias_q <= 1'b0;
            frontFaceWinding_q <= 1'b0;
            backFaceCull_q <= 1'b0;
            topLeftRuleDisable_q <= 1'b0;
            primInTriangleRange_q <= 1'b0;
        end else if (primStart) begin
            if (isLine) begin
                // Thick, dash-orientation, border and shadow bits are masked while any vertex attribute is enabled
                thickLineOrientation_q <= extOk & lineModeExt_q[`GPM_BIT_THICK_ORIENT];
                thickJointCorrection_q <= extOk & lineModeExt_q[`GPM_BIT_THICK_JOINT];
                dashPatternOrientation_q <= extOk & lineModeExt_q[`GPM_BIT_DASH_ORIENT];
                borderPrimitiveEnable_q <= extOk & lineModeExt_q[`GPM_BIT_BORDER];
                shadowPrimitiveEnable_q <= extOk & lineModeExt_q[`GPM_BIT_SHADOW];
                // Bit 0 means clear the reference
                dashReferenceClear_q <= ~lineModeExt_q[`GPM_BIT_DASH_REF];
                endPointDraw_q <= lineModeExt_q[`GPM_BIT_END_POINT]
                    & (primKind != `GPM_MODE_STRIP);
                lineAntialias_q <= lineModeExt_q[`GPM_BIT_ANTIALIAS];
                frontFaceWinding_q <= 1'b0;
                backFaceCull_q <= 1'b0;
                topLeftRuleDisable_q <= 1'b0;
                primInTriangleRange_q <= 1'b0;
            end else if (isTri) begin
                thickLineOrientation_q <= 1'b0;
                thickJointCorrection_q <= 1'b0;
                dashPatternOrientation_q <= 1'b0;
                borderPrimitiveEnable_q <= 1'b0;
                shadowPrimitiveEnable_q <= triangleModeExt_q[`GPM_BIT_SHADOW];
                dashReferenceClear_q <= 1'b0;
                endPointDraw_q <= 1'b0;
                lineAntialias_q <= 1'b0;
                // Both triangle settings carry the winding; either set selects CCW
                frontFaceWinding_q <= triangleMode_q[`GPM_BIT_WINDING]
                    | triangleModeExt_q[`GPM_BIT_WINDING];
                backFaceCull_q <= (primKind == `GPM_MODE_TRI)
                    & (triangleMode_q[`GPM_BIT_CULL]
                    | triangleModeExt_q[`GPM_BIT_CULL]);
                topLeftRuleDisable_q <= triangleModeExt_q[`GPM_BIT_TOP_LEFT];
                primInTriangleRange_q <= primActive;
            end
        end
    end
endmodule // gpm_geometry_primitive_mode_regs

// >>> rtl/gpm_map.vh
// Purpose: Offsets, field positions, reset values for geometry mode registers
// Assumes: Byte offsets from the geometry base
// Notes: Definitions only
`ifndef GPM_MAP_VH
`define GPM_MAP_VH
`define GPM_OFS_VERTEX_MODE 12'h040
`define GPM_OFS_LINE_MODE 12'h044
`define GPM_OFS_TRIANGLE_MODE 12'h048
`define GPM_OFS_LINE_MODE_EXT 12'h04c
`define GPM_OFS_TRIANGLE_MODE_EXT 12'h050
`define GPM_OFS_FIFO_PORT 12'h400
`define GPM_RST_MODE 32'h00000000
`define GPM_BIT_ANTIALIAS 0
`define GPM_BIT_END_POINT 2
`define GPM_BIT_DASH_REF 4
`define GPM_BIT_SHADOW 8
`define GPM_BIT_BORDER 9
`define GPM_BIT_TOP_LEFT 10
`define GPM_BIT_THICK_ORIENT 12
`define GPM_BIT_DASH_ORIENT 13
`define GPM_BIT_THICK_JOINT 20
`define GPM_BIT_CULL 0
`define GPM_BIT_WINDING 2
`define GPM_BIT_VTX_COLOR 1
`define GPM_BIT_VTX_DEPTH 2
`define GPM_BIT_VTX_TEX 3
`define GPM_MODE_LINE 2'h0
`define GPM_MODE_STRIP 2'h1
`define GPM_MODE_TRI 2'h2
`define GPM_MODE_POLY 2'h3
`endif

// >>> rtl/gpm_fifo_port.v
// Purpose: Display-list FIFO entry port, write-only word push
// Assumes: Consumer accepts with wordReady; one word staged
// Notes: Write while staged word is pending is held off by portReady
module gpm_fifo_port (
    input wire clk_sys,
    input wire rst_n,
    input wire wrEn,
    input wire [31:0] wrData,
    output wire portReady,
    output reg wordValid_q,
    output reg [31:0] wordData_q,
    input wire wordReady
);
    assign portReady = ~wordValid_q | wordReady;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wordValid_q <= 1'b0;
            wordData_q <= 32'h00000000;
        end else if (wrEn && portReady) begin
            wordValid_q <= 1'b1;
            wordData_q <= wrData;
        end else if (wordReady) begin
            wordValid_q <= 1'b0;
        end
    end
endmodule // gpm_fifo_port

// >>> tb/gpm_mode_assertions.sv
// Purpose: Port checks for the mode settings block
// Assumes: One clock, async active-low reset
// Notes: Helpers mirror written modes so checks need no internals
module gpm_mode_assertions (
    input logic clk_sys, rst_n, cmdWrEn, cmdWrReady, primStart, primActive, wordValid_q,
    input logic [11:0] cmdWrAddr,
    input logic [31:0] cmdWrData, wordData_q,
    input logic [1:0] primKind,
    input logic lineAntialias_q, endPointDraw_q, dashReferenceClear_q,
    input logic borderPrimitiveEnable_q, frontFaceWinding_q, backFaceCull_q,
    input logic topLeftRuleDisable_q, primInTriangleRange_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [31:0] lx, tm, te, vm, sl, st, sx, sv;
    // Latched at primitive start, as the block must do
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {lx, tm, te, vm, sl, st, sx, sv} <= '0;
        end else begin
            if (cmdWrEn && cmdWrAddr == 12'h04c) lx <= cmdWrData;
            if (cmdWrEn && cmdWrAddr == 12'h048) tm <= cmdWrData;
            if (cmdWrEn && cmdWrAddr == 12'h050) te <= cmdWrData;
            if (cmdWrEn && cmdWrAddr == 12'h040) vm <= cmdWrData;
            if (primStart) {sl, st, sx, sv} <= {lx, tm | te, te, vm};
        end
    end
    sequence lineGo; primStart && primKind == 2'h0; endsequence
    sequence triGo; primStart && primKind == 2'h2; endsequence
    AST_AA: assert property (lineGo |=> lineAntialias_q == sl[0])
        else $error("antialias wrong");
    AST_EP: assert property (lineGo |=> endPointDraw_q == sl[2])
        else $error("end point wrong");
    AST_STRIP: assert property (primStart && primKind == 2'h1 |=> !endPointDraw_q)
        else $error("strip end point");
    AST_DASH: assert property (lineGo |=> dashReferenceClear_q == !sl[4])
        else $error("dash reference wrong");
    AST_BORDER: assert property (lineGo |=> borderPrimitiveEnable_q == (sl[9] && sv[3:1] == 0))
        else $error("border wrong");
    AST_TRI: assert property (triGo |=> {frontFaceWinding_q, backFaceCull_q, topLeftRuleDisable_q}
        == {st[2], st[0], sx[10]})
        else $error("triangle modes wrong");
    AST_POLY: assert property (primStart && primKind == 2'h3 |=> !backFaceCull_q)
        else $error("polygon culled");
    AST_RANGE: assert property (triGo |=> primInTriangleRange_q == $past(primActive))
        else $error("range flag wrong");
    AST_HOLD: assert property (!primStart |=> $stable({lineAntialias_q, backFaceCull_q}))
        else $error("mode changed mid primitive");
    AST_FIFO: assert property (cmdWrEn && cmdWrAddr == 12'h400 && cmdWrReady |->
        ##2 wordValid_q && wordData_q == $past(cmdWrData, 2))
        else $error("fifo word lost");
endmodule // gpm_mode_assertions

// >>> tb/gpm_list_sink.sv
// Purpose: Display-list word consumer model
// Assumes: Stall input makes it slow
// Notes: Ready lags stall by a cycle, no kinder than real logic
module gpm_list_sink (
    input logic clk_sys,
    input logic rst_n,
    input logic stall,
    input logic wordValid_q,
    input logic [31:0] wordData_q,
    output logic wordReady,
    output logic [31:0] lastWord_q
);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wordReady <= 1'b0;
            lastWord_q <= 32'h0;
        end else begin
            wordReady <= !stall;
            if (wordValid_q) lastWord_q <= wordData_q;
        end
    end
endmodule // gpm_list_sink

// >>> tb/test_geometry_primitive_mode_regs.sv
// Purpose: Self-checking bench for the geometry mode settings
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Mode outputs packed into modeBus
module test_geometry_primitive_mode_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_n = 0, cmdWrEn = 0, primStart = 0, primActive = 0, stall = 1;
    logic [11:0] cmdWrAddr = 12'h000, modeBus;
    logic [31:0] cmdWrData = 32'h0, wordData_q, lastWord_q;
    logic [1:0] primKind = 2'h0;
    logic cmdWrReady, wordReady, wordValid_q;
    int fail_count = 0, n_tests = 0, cycles = 0;
    gpm_geometry_primitive_mode_regs u_gpm_geometry_primitive_mode_regs (.clk_sys(clk_sys),
        .rst_n(rst_n), .cmdWrEn(cmdWrEn), .cmdWrAddr(cmdWrAddr), .cmdWrData(cmdWrData),
        .cmdWrReady(cmdWrReady), .primStart(primStart), .primKind(primKind),
        .primActive(primActive), .wordValid_q(wordValid_q), .wordData_q(wordData_q),
        .wordReady(wordReady), .lineAntialias_q(modeBus[0]), .endPointDraw_q(modeBus[1]),
        .dashReferenceClear_q(modeBus[2]), .shadowPrimitiveEnable_q(modeBus[3]),
        .borderPrimitiveEnable_q(modeBus[4]), .thickLineOrientation_q(modeBus[5]),
        .thickJointCorrection_q(modeBus[6]), .dashPatternOrientation_q(modeBus[7]),
        .frontFaceWinding_q(modeBus[8]), .backFaceCull_q(modeBus[9]),
        .topLeftRuleDisable_q(modeBus[10]), .primInTriangleRange_q(modeBus[11]));
    gpm_list_sink u_gpm_list_sink (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
        .wordValid_q(wordValid_q), .wordData_q(wordData_q), .wordReady(wordReady),
        .lastWord_q(lastWord_q));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Idle cycle after each strobe so a following call never re-drives it in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        {cmdWrEn, cmdWrAddr, cmdWrData} = {1'b1, a, d};
        @(posedge clk_sys);
        #2 cmdWrEn = 0;
        @(posedge clk_sys);
        #2;
    endtask
    task automatic prim(input logic [1:0] k, input logic act);
        {primStart, primKind, primActive} = {1'b1, k, act};
        @(posedge clk_sys);
        #2 primStart = 0;
        @(posedge clk_sys);
        #2;
    endtask
    task automatic close_out;
        $display("tests=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            close_out;
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        #2 rst_n = 1;
        chk(modeBus, 0);
        prim(2'h0, 0);
        chk(modeBus, 12'h004);
        wr(12'h04c, 32'h00103315);
        prim(2'h0, 0);
        chk(modeBus, 12'h0fb);
        prim(2'h1, 0);
        chk(modeBus, 12'h0f9);
        wr(12'h04c, 32'h0);
        chk(modeBus, 12'h0f9);
        wr(12'h040, 32'h2);
        wr(12'h04c, 32'h00103315);
        prim(2'h0, 0);
        chk(modeBus, 12'h003);
        $display("line modes done");
        wr(12'h048, 32'h5);
        prim(2'h2, 1);
        chk(modeBus[11:8], 4'hb);
        prim(2'h3, 1);
        chk(modeBus[10:8], 3'h1);
        wr(12'h048, 32'h0);
        wr(12'h050, 32'h505);
        wr(12'h0ff, 32'hffffffff);
        prim(2'h2, 0);
        chk(modeBus, 12'h708);
        $display("triangle modes done");
        wr(12'h400, 32'hcafe0001);
        chk({wordValid_q, cmdWrReady}, 2'h2);
        chk(wordData_q, 32'hcafe0001);
        wr(12'h400, 32'hcafe0002);
        stall = 0;
        repeat (8) @(posedge clk_sys);
        #2 chk({wordValid_q, lastWord_q}, {1'b0, 32'hcafe0001});
        wr(12'h400, 32'hcafe0003);
        repeat (4) @(posedge clk_sys);
        #2 chk(lastWord_q, 32'hcafe0003);
        $display("fifo port done");
        close_out;
    end
endmodule // test_geometry_primitive_mode_regs
bind gpm_geometry_primitive_mode_regs gpm_mode_assertions u_gpm_mode_assertions (.*);
